// [shared/usb_int_pkg.sv]
package usb_int_pkg;

	localparam int ADDR_W = 8;
	localparam int NUM_DMA_EP = 5;
	localparam int NUM_HALT_EP = 7;

	// Byte addresses of the word-aligned registers.
	localparam logic [7:0] OFS_STATUS_A = 8'h00;
	localparam logic [7:0] OFS_STATUS_B = 8'h04;
	localparam logic [7:0] OFS_CLEAR_A = 8'h08;
	localparam logic [7:0] OFS_CLEAR_B = 8'h0c;
	localparam logic [7:0] OFS_DMA_ENABLE = 8'h10;
	localparam logic [7:0] OFS_DMA_STATUS = 8'h14;
	localparam logic [7:0] OFS_HALT_STATUS = 8'h18;
	localparam logic [7:0] OFS_STALL_FORCE = 8'h1c;

	// Bit positions in usb_int_source_status_a.
	localparam int BIT_STALL = 0;
	localparam int BIT_CLEAR = 1;
	localparam int BIT_SET = 2;
	localparam int BIT_DMA_END = 3;

	// Bit positions in usb_int_source_status_b.
	localparam int BIT_STAGE_ERR = 0;
	localparam int BIT_SETUP_OK = 1;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CLEAR_RD = 8'hff;
	localparam logic [4:0] DMA_EN_RST = 5'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	localparam logic HRESP_OKAY = 1'b0;

	// One-cycle event pulses from the serial interface engine.
	typedef struct packed {
		logic setup_rcvd;
		logic status_done;
		logic auto_set;
		logic auto_clear;
		logic set_feature_ep;
		logic ep0_mask_req;
		logic ep_stall;
	} sie_evt_t;

	typedef struct packed {
		logic        sel;
		logic [31:0] addr;
		logic [1:0]  trans;
		logic        write;
		logic [2:0]  size;
		logic        ready;
	} ahb_addr_t;

endpackage : usb_int_pkg

// [logic/usb_int_flags.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Transfer end on DMA endpoint 1-4 or 7 sets status_a bit 3.
// - A set DMA-end drops that endpoint's DMA request.
// - DMA request stays off until firmware enables that endpoint again.
// - Reading the DMA endpoint status leaves the DMA-end flag set.
// - Self-handled SET_CONFIGURATION or SET_FEATURE sets status_a bit 2.
// - SET flag rises only after status stage; target read does not clear.
// - SET_FEATURE to an endpoint also sets the stall flag.
// - Self-handled CLEAR_FEATURE sets status_a bit 1.
// - CLEAR flag rises only after status stage; target read does not clear.
// - Any endpoint entering stall sets status_a bit 0.
// - Firmware forcing a stall also sets the stall flag.
// - Stall flag survives CLEAR_FEATURE, SET_INTERFACE, SET_CONFIGURATION.
// - Stall flag survives the SETUP following an endpoint 0 overrun.
// - Endpoint 0 halt bit reads 0 from masking request to next other SETUP.
// - Any change in status_b pulses the endpoint controller interrupt.
// - status_b is read-only, eight bits wide.
// - Writing 0 to a clear-control bit clears the matching status bit.
// - Next SETUP clears setup-success and stage-error in status_b.
// - All interrupt sources are ORed into one shared request.
module usb_int_flags
	import usb_int_pkg::*;
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	input  wire sie_evt_t               sie_evt,
	input  wire logic [7:0]             status_b_evt,
	input  wire logic [NUM_DMA_EP-1:0]  transfer_end_input,
	input  wire logic [NUM_DMA_EP-1:0]  dma_ready,
	input  wire logic [NUM_HALT_EP-1:0] halt_in,
	output logic      [NUM_DMA_EP-1:0]  dma_request,
	output logic      [NUM_HALT_EP-1:0] stall_force,
	output logic                        endpoint_ctrl_irq_out,
	output logic                        usb_shared_irq
);

	// Sticky flag update: a set arriving with a clear wins. Firmware that
	// clears a bit in the same cycle as a new event must not lose the event,
	// so the set term is applied after the clear term.
	function automatic logic [7:0] flag_upd(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] clr
	);
		flag_upd = (cur & ~clr) | set;
	endfunction : flag_upd

	// Compares a word address against a register offset of the same width.
	function automatic logic addr_is(
		input logic [ADDR_W-1:0] a,
		input logic [7:0]        ofs
	);
		addr_is = (a == ofs);
	endfunction : addr_is

	ahb_addr_t               ap;
	logic                    wr_pend_r;
	logic [ADDR_W-1:0]       wr_addr_r;
	logic                    ap_valid;
	logic                    wr_now;
	logic [7:0]              wbyte;
	logic [7:0]              status_a_r;
	logic [7:0]              status_a_nxt;
	logic [7:0]              status_b_r;
	logic [7:0]              status_b_nxt;
	logic [7:0]              clr_a;
	logic [7:0]              clr_b;
	logic [7:0]              set_a;
	logic [7:0]              set_b;
	logic [NUM_DMA_EP-1:0]   dma_en_r;
	logic [NUM_DMA_EP-1:0]   dma_stat_r;
	logic [NUM_DMA_EP-1:0]   dma_wr_set;
	logic [NUM_DMA_EP-1:0]   dma_end_hit;
	logic                    pend_set_r;
	logic                    pend_stall_r;
	logic                    pend_clr_r;
	logic                    ep0_mask_r;
	logic [NUM_HALT_EP-1:0]  halt_view;
	logic [NUM_HALT_EP-1:0]  force_req;
	logic [31:0]             rd_word;

	// The address phase travels as one bundle; a transfer is taken only
	// when the previous one has completed on the bus.
	assign ap = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite,
		size: hsize, ready: hready};
	assign ap_valid = ap.sel && ap.ready &&
		(ap.trans == HTRANS_NONSEQ || ap.trans == HTRANS_SEQ);
	// Write data stands in the cycle after the address phase; only the low
	// byte carries register bits.
	assign wr_now = wr_pend_r;
	assign wbyte = hwdata[7:0];

	// The slave never inserts wait states and always answers OKAY. Unmapped
	// addresses read as zero and ignore writes rather than raising an error.
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;

	// A write is taken in its address phase and applied one cycle later,
	// when the master drives the data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_pend_r <= 1'b0;
		else
			wr_pend_r <= ap_valid && ap.write;
	end

	// Only the word address is kept, so byte offsets inside a word never
	// select a different register. The value is harmless while no write
	// is pending.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_addr_r <= '0;
		else if (ap_valid)
			wr_addr_r <= {ap.addr[ADDR_W-1:2], 2'b00};
	end

	// Write decode. Clear-control bits act only where 0 is written.
	// Writing all ones therefore leaves every flag alone, which lets
	// firmware clear one source at a time without touching the others.
	always_comb begin
		clr_a = 8'h00;
		clr_b = 8'h00;
		dma_wr_set = '0;
		force_req = '0;
		if (wr_now) begin
			if (addr_is(wr_addr_r, OFS_CLEAR_A))
				clr_a = ~wbyte;
			if (addr_is(wr_addr_r, OFS_CLEAR_B))
				clr_b = ~wbyte;
			if (addr_is(wr_addr_r, OFS_DMA_ENABLE))
				dma_wr_set = wbyte[NUM_DMA_EP-1:0];
			if (addr_is(wr_addr_r, OFS_STALL_FORCE))
				force_req = wbyte[NUM_HALT_EP-1:0];
		end
	end

	// Per DMA endpoint: enable, end capture and request gating.
	// Index 0 to 4 stands for endpoints 1, 2, 3, 4 and 7. An end pulse
	// counts only while the endpoint is enabled, so a late pulse from the
	// DMA controller after the endpoint was stopped is ignored.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DMA_EP; gi++) begin : g_dma
			assign dma_end_hit[gi] = transfer_end_input[gi] && dma_en_r[gi];

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					dma_en_r[gi] <= DMA_EN_RST[gi];
				end else if (dma_end_hit[gi]) begin
					dma_en_r[gi] <= 1'b0;
				end else if (dma_wr_set[gi]) begin
					dma_en_r[gi] <= 1'b1;
				end
			end

			// Endpoint status is dropped only by re-enabling, never by a read.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					dma_stat_r[gi] <= 1'b0;
				end else if (dma_end_hit[gi]) begin
					dma_stat_r[gi] <= 1'b1;
				end else if (dma_wr_set[gi]) begin
					dma_stat_r[gi] <= 1'b0;
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					dma_request[gi] <= 1'b0;
				else
					dma_request[gi] <= dma_en_r[gi] && !dma_end_hit[gi] &&
						dma_ready[gi];
			end
		end
	endgenerate

	// Self-handled requests wait here for their status stage. A new
	// request replaces an older one, and a SETUP abandons a request whose
	// status stage never came, so a stale request cannot raise a flag for
	// a later transfer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend_set_r <= 1'b0;
		else if (sie_evt.auto_set || sie_evt.auto_clear)
			pend_set_r <= sie_evt.auto_set;
		else if (sie_evt.status_done || sie_evt.setup_rcvd)
			pend_set_r <= 1'b0;
	end

	// A SET_FEATURE aimed at an endpoint also owes a stall flag.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend_stall_r <= 1'b0;
		else if (sie_evt.auto_set || sie_evt.auto_clear)
			pend_stall_r <= sie_evt.auto_set && sie_evt.set_feature_ep;
		else if (sie_evt.status_done || sie_evt.setup_rcvd)
			pend_stall_r <= 1'b0;
	end

	// A self-handled CLEAR_FEATURE waits the same way.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend_clr_r <= 1'b0;
		else if (sie_evt.auto_set || sie_evt.auto_clear)
			pend_clr_r <= sie_evt.auto_clear;
		else if (sie_evt.status_done || sie_evt.setup_rcvd)
			pend_clr_r <= 1'b0;
	end

	// Setting events of the first register. The upper bits have no source
	// in this block and stay clear.
	always_comb begin
		set_a = 8'h00;
		set_a[BIT_DMA_END] = |dma_end_hit;
		set_a[BIT_SET] = pend_set_r && sie_evt.status_done;
		set_a[BIT_CLEAR] = pend_clr_r && sie_evt.status_done;
		set_a[BIT_STALL] = sie_evt.ep_stall || (|force_req) ||
			(pend_stall_r && sie_evt.status_done);
	end

	// The stall flag has no automatic clear; only firmware clears it.
	// Requests that lift a halt, or a SETUP after an overrun, leave it set
	// so that firmware still sees which stall it has not yet handled.
	assign status_a_nxt = flag_upd(status_a_r, set_a, clr_a);

	// Both status registers start clear and only events set them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status_a_r <= STATUS_RST;
		else
			status_a_r <= status_a_nxt;
	end

	// Second register: each one-cycle source pulse sets its own bit, which then holds until cleared.
	always_comb begin
		set_b = status_b_evt;
	end

	// A SETUP clears the setup-success and stage-error bits, which would
	// otherwise describe a control transfer that has already been replaced.
	logic [7:0] clr_b_all;
	always_comb begin
		clr_b_all = clr_b;
		if (sie_evt.setup_rcvd) begin
			clr_b_all[BIT_SETUP_OK] = 1'b1;
			clr_b_all[BIT_STAGE_ERR] = 1'b1;
		end
	end

	// A new stage error in the same cycle as a SETUP is kept, in line with
	// the set-wins rule used for every flag.
	assign status_b_nxt = flag_upd(status_b_r, set_b, clr_b_all);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status_b_r <= STATUS_RST;
		else
			status_b_r <= status_b_nxt;
	end

	// Endpoint 0 halt masking window. The halt itself is untouched; only
	// the view that firmware reads is forced to zero until a SETUP that
	// does not open a new window arrives.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ep0_mask_r <= 1'b0;
		else if (sie_evt.ep0_mask_req)
			ep0_mask_r <= 1'b1;
		else if (sie_evt.setup_rcvd)
			ep0_mask_r <= 1'b0;
	end

	always_comb begin
		halt_view = halt_in;
		if (ep0_mask_r)
			halt_view[0] = 1'b0;
	end

	// Firmware stall requests leave as a one-cycle pulse to the endpoint
	// logic; the stall flag is set by the same write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			stall_force <= '0;
		else
			stall_force <= force_req;
	end

	// Change pulse on either status register. It rises in the same cycle
	// as the flag that changed, on a set as well as on a clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			endpoint_ctrl_irq_out <= 1'b0;
		else
			endpoint_ctrl_irq_out <= (status_a_nxt != status_a_r) ||
				(status_b_nxt != status_b_r);
	end

	// The shared request is a level: it stays high while any flag is set,
	// so clearing one source while another remains keeps it asserted.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			usb_shared_irq <= 1'b0;
		else
			usb_shared_irq <= (|status_a_nxt) || (|status_b_nxt);
	end

	// Read mux; status registers have no write path. Next-state values are
	// returned so that a read never misses an event of the same cycle.
	always_comb begin
		rd_word = 32'h0000_0000;
		case ({ap.addr[ADDR_W-1:2], 2'b00})
			OFS_STATUS_A:    rd_word[7:0] = status_a_nxt;
			OFS_STATUS_B:    rd_word[7:0] = status_b_nxt;
			OFS_CLEAR_A:     rd_word[7:0] = CLEAR_RD;
			OFS_CLEAR_B:     rd_word[7:0] = CLEAR_RD;
			OFS_DMA_ENABLE:  rd_word[NUM_DMA_EP-1:0] = dma_en_r;
			OFS_DMA_STATUS:  rd_word[NUM_DMA_EP-1:0] = dma_stat_r;
			OFS_HALT_STATUS: rd_word[NUM_HALT_EP-1:0] = halt_view;
			default:         rd_word = 32'h0000_0000;
		endcase
	end

	// Read data is captured at the end of the address phase and holds
	// through the data phase until the next read is taken.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (ap_valid && !ap.write)
			hrdata <= rd_word;
	end

endmodule : usb_int_flags

// [bench/usb_int_flags_sva.sv]
`timescale 1ns/1ps
module usb_int_flags_chk
	import usb_int_pkg::*;
(
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire sie_evt_t               sie_evt,
	input wire logic [7:0]             status_b_evt,
	input wire logic [NUM_DMA_EP-1:0]  transfer_end_input,
	input wire logic [NUM_DMA_EP-1:0]  dma_request,
	input wire logic [NUM_HALT_EP-1:0] stall_force,
	input wire logic                   endpoint_ctrl_irq_out,
	input wire logic                   usb_shared_irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	dma_drop_a: assert property (
		|(transfer_end_input & dma_request) |=>
		(dma_request & $past(transfer_end_input)) == '0)
		else $error("dma request kept after transfer end");
	dma_irq_a: assert property (
		|(transfer_end_input & dma_request) |=> usb_shared_irq)
		else $error("no irq after dma end");
	stall_irq_a: assert property (
		sie_evt.ep_stall |=> usb_shared_irq)
		else $error("no irq after endpoint stall");
	force_irq_a: assert property (
		|stall_force |-> ##[0:1] usb_shared_irq)
		else $error("no irq after forced stall");
	rise_cause_a: assert property (
		$rose(usb_shared_irq) |-> $past(sie_evt.status_done ||
		sie_evt.ep_stall || sie_evt.set_feature_ep || |status_b_evt ||
		|transfer_end_input || |stall_force) || |stall_force)
		else $error("irq rose without a setting event");
	rise_pulse_a: assert property (
		$rose(usb_shared_irq) |-> endpoint_ctrl_irq_out)
		else $error("no change pulse on flag set");
	fall_pulse_a: assert property (
		$fell(usb_shared_irq) |-> endpoint_ctrl_irq_out)
		else $error("no change pulse on flag clear");
	reset_quiet_a: assert property (
		$rose(hresetn) |-> !usb_shared_irq)
		else $error("irq active right after reset");
endmodule : usb_int_flags_chk

bind usb_int_flags usb_int_flags_chk usb_int_flags_chk_inst (
	.hclk(hclk), .hresetn(hresetn), .sie_evt(sie_evt),
	.status_b_evt(status_b_evt), .transfer_end_input(transfer_end_input),
	.dma_request(dma_request), .stall_force(stall_force),
	.endpoint_ctrl_irq_out(endpoint_ctrl_irq_out),
	.usb_shared_irq(usb_shared_irq)
);

// [bench/usb_dma_model.sv]
`timescale 1ns/1ps
module usb_dma_model
	import usb_int_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic [NUM_DMA_EP-1:0] dma_request,
	output logic      [NUM_DMA_EP-1:0] dma_ready,
	output logic      [NUM_DMA_EP-1:0] transfer_end_input
);
	logic [1:0] cnt_r = 2'h0;
	// Ends a transfer four cycles after a request has stood.
	always @(posedge hclk) begin
		dma_ready <= '1;
		transfer_end_input <= '0;
		cnt_r <= (|dma_request) ? cnt_r + 2'h1 : 2'h0;
		if (cnt_r == 2'h3) begin
			transfer_end_input <= dma_request;
		end
	end
endmodule : usb_dma_model

// [bench/usb_int_flags_tb_top.sv]
`timescale 1ns/1ps
module usb_int_flags_tb_top
	import usb_int_pkg::*;
;
	localparam sie_evt_t E_STALL = 7'h01;
	localparam sie_evt_t E_MASK  = 7'h02;
	localparam sie_evt_t E_SETF  = 7'h04;
	localparam sie_evt_t E_ACLR  = 7'h08;
	localparam sie_evt_t E_ASET  = 7'h10;
	localparam sie_evt_t E_DONE  = 7'h20;
	localparam sie_evt_t E_SETUP = 7'h40;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd_v;
	logic        hreadyout, hresp, eirq, sirq;
	sie_evt_t    sie_evt = '0;
	logic [7:0]  status_b_evt = 8'h00;
	logic [6:0]  halt_in = 7'h00;
	logic [6:0]  stall_force;
	logic [4:0]  dma_ready, tend, dma_request;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	usb_int_flags usb_int_flags_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .sie_evt(sie_evt),
		.status_b_evt(status_b_evt), .transfer_end_input(tend),
		.dma_ready(dma_ready), .halt_in(halt_in),
		.dma_request(dma_request), .stall_force(stall_force),
		.endpoint_ctrl_irq_out(eirq), .usb_shared_irq(sirq)
	);
	usb_dma_model usb_dma_model_inst (
		.hclk(hclk), .dma_request(dma_request),
		.dma_ready(dma_ready), .transfer_end_input(tend)
	);
	initial begin
		forever #5 hclk = ~hclk;
	end
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_v = hrdata;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask : rd
	task automatic ev(input sie_evt_t e, input logic [7:0] b);
		sie_evt <= e;
		status_b_evt <= b;
		@(posedge hclk);
		sie_evt <= '0;
		status_b_evt <= 8'h00;
		@(posedge hclk);
	endtask : ev
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_STATUS_A, 32'h0);
		rd(OFS_STATUS_B, 32'h0);
		rd(8'h40, 32'h0);
		ev(E_STALL, 8'h00);
		rd(OFS_STATUS_A, 32'h0000_0001);
		chk({31'h0, sirq}, 32'h1);
		ev(E_SETUP, 8'h00);
		ev(E_ACLR, 8'h00);
		rd(OFS_STATUS_A, 32'h0000_0001);
		ev(E_DONE, 8'h00);
		rd(OFS_STATUS_A, 32'h0000_0003);
		xfer(1'b1, OFS_STATUS_A, 32'h0);
		rd(OFS_STATUS_A, 32'h0000_0003);
		xfer(1'b1, OFS_CLEAR_A, 32'h0000_00fe);
		rd(OFS_STATUS_A, 32'h0000_0002);
		xfer(1'b1, OFS_CLEAR_A, 32'h0000_00fd);
		rd(OFS_STATUS_A, 32'h0);
		chk({31'h0, sirq}, 32'h0);
		$display("test control flags done");
		ev(E_ASET | E_SETF, 8'h00);
		xfer(1'b0, OFS_STATUS_A, 32'h0);
		chk({31'h0, rd_v[BIT_SET]}, 32'h0);
		ev(E_DONE, 8'h00);
		rd(OFS_STATUS_A, 32'h0000_0005);
		xfer(1'b1, OFS_CLEAR_A, 32'h0000_00fa);
		ev('0, 8'h83);
		rd(OFS_STATUS_B, 32'h0000_0083);
		xfer(1'b1, OFS_STATUS_B, 32'h0);
		rd(OFS_STATUS_B, 32'h0000_0083);
		ev(E_SETUP, 8'h00);
		rd(OFS_STATUS_B, 32'h0000_0080);
		xfer(1'b1, OFS_CLEAR_B, 32'h0000_007f);
		rd(OFS_STATUS_B, 32'h0);
		chk({31'h0, sirq}, 32'h0);
		$display("test second status done");
		xfer(1'b1, OFS_STALL_FORCE, 32'h0000_0001);
		rd(OFS_STATUS_A, 32'h0000_0001);
		xfer(1'b1, OFS_CLEAR_A, 32'h0000_00fe);
		halt_in <= 7'h01;
		rd(OFS_HALT_STATUS, 32'h0000_0001);
		ev(E_MASK, 8'h00);
		rd(OFS_HALT_STATUS, 32'h0);
		ev(E_SETUP, 8'h00);
		rd(OFS_HALT_STATUS, 32'h0000_0001);
		$display("test stall done");
		for (int i = 0; i < NUM_DMA_EP; i++) begin
			xfer(1'b1, OFS_DMA_ENABLE, 32'h1 << i);
			repeat (12) @(posedge hclk);
			chk({27'h0, dma_request}, 32'h0);
			rd(OFS_STATUS_A, 32'h0000_0008);
			xfer(1'b0, OFS_DMA_STATUS, 32'h0);
			chk({31'h0, rd_v[i]}, 32'h1);
			rd(OFS_STATUS_A, 32'h0000_0008);
			xfer(1'b1, OFS_CLEAR_A, 32'h0000_00f7);
		end
		$display("test dma done");
		test_done();
	end
endmodule : usb_int_flags_tb_top
